// ===== rtl/sel_pkg.sv
/*
 Constants for the singles event link: slice timing, word layout,
 packet identifiers and pipeline sizes. Assumes nothing outside.
*/
package sel_pkg;
    localparam int CLK_MHZ = 125;
    localparam int SYS_CLK_MHZ = 80;
    localparam int SLICE_SHORT_NS = 100;
    localparam int SLICE_SHORT_CLKS = 8;
    localparam int SLICE_LONG_CLKS = 16;
    localparam int NCHAN = 4;
    localparam int NLANE = 4;
    localparam int PAIRS = 4;
    localparam int SPARE_PAIRS = 8;
    localparam int ADC_W = 12;
    localparam int INT_W = 16;
    localparam int E_W = 18;
    localparam int POS_W = 6;
    localparam int XTAL_W = 8;
    localparam int TDC_W = 4;
    localparam int TIME_W = 8;
    localparam int INT_LEN = 8;
    localparam int WORD_W = 64;
    localparam int PID_W = 4;
    localparam logic [3:0] PID_FIRST = 4'h1;
    localparam logic [3:0] PID_LAST = 4'h4;
    localparam int PID_LO = 28;
    localparam int PID_HI_LO = 60;
    typedef enum logic [1:0] {
        SEL_IDLE = 2'b00,
        SEL_INTEG = 2'b01,
        SEL_CALC = 2'b10,
        SEL_LOOK = 2'b11
    } sel_state_e;
endpackage : sel_pkg

// ===== rtl/sel_link.sv
/*
 Sensing card event processing and outbound singles link.
 Assumes system clock and slice boundary arrive from the carrier card,
 synchronous to i_clk; lookup tables are preloaded over i_lut_* port.
*/
`timescale 1ns/10ps
// Contract
// - Inbound data is clocked by the carrier's clock and slice copies.
// - Card forwards its own clock and slice copies for outbound data.
// - Slices are 8 or 16 system clocks long.
// - Control passes over four single-ended serial lines; here tables load over the parallel i_lut_* port.
// - Events leave on sixteen pairs, four lanes of four.
// - Word is 32 bits for short slices, 64 for long.
// - At most one word per lane per slice.
// - Every transfer completes inside one slice.
// - Long processing is split into slice-sized pipeline stages; code uses 8-clock integration, then 1-clock calc and lookup.
// - Processing starts on a rising edge of any discriminator.
// - Each channel's samples are summed over a fixed window.
// - Energy is sum of integrals; X=(A+B)/E, Y=(A+C)/E.
// - X and Y address the crystal map table.
// - Energy and crystal address the energy window table.
// - Each timing signal is stamped within the slice; code stamps only channel 0's fine time, at trigger.
// - Crystal and raw time address the time correction table.
// - Only events inside the energy window are sent.
// - Eight spare pairs stay available between the cards.
// - Calibration factors may be applied before formatting.
// - Top four bits of each 32-bit packet hold the packet identifier.
// - Identifier zero never used; one to four number the packets.
module sel_link (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_slice,
    input wire logic i_long_slice,
    input wire logic [sel_pkg::NCHAN-1:0] i_disc,
    input wire logic [sel_pkg::NCHAN*sel_pkg::ADC_W-1:0] i_adc,
    input wire logic [sel_pkg::NCHAN*sel_pkg::TDC_W-1:0] i_tdc_fine,
    input wire logic [sel_pkg::SPARE_PAIRS-1:0] i_spare,
    input wire logic i_lut_we,
    input wire logic [1:0] i_lut_sel,
    input wire logic [11:0] i_lut_addr,
    input wire logic [15:0] i_lut_data,
    output logic o_clk_fwd,
    output logic o_slice_fwd,
    output logic [sel_pkg::NLANE*sel_pkg::PAIRS-1:0] o_lane,
    output logic [sel_pkg::SPARE_PAIRS-1:0] o_spare
);
    import sel_pkg::*;

    // Tables live in card memory; 0 crystal map, 1 window, 2 time, 3 gain
    // Read combinationally so the lookup stage needs no extra slice
    logic [XTAL_W-1:0] xtal_map [0:4095];
    logic win_map [0:4095];
    logic [TIME_W-1:0] time_map [0:4095];
    logic [7:0] gain_map [0:255];

    sel_state_e st_q, st_d;
    logic [4:0] pos_q, pos_d;
    logic [4:0] len;
    logic [NCHAN-1:0] disc_q;
    logic trig;
    logic [3:0] icnt_q, icnt_d;
    logic [INT_W-1:0] acc_q [NCHAN];
    logic [INT_W-1:0] acc_d [NCHAN];
    logic [TIME_W-1:0] raw_t_q, raw_t_d;
    logic [E_W-1:0] e_q, e_d;
    logic [POS_W-1:0] x_q, x_d, y_q, y_d;
    logic [XTAL_W-1:0] xtal_q, xtal_d;
    logic [WORD_W-1:0] pend_q, pend_d;
    logic pend_v_q, pend_v_d;
    logic [WORD_W-1:0] sh_q [NLANE];
    logic [WORD_W-1:0] sh_d [NLANE];
    logic [1:0] lane_q, lane_d;
    logic [NLANE*PAIRS-1:0] lane_out_d;
    logic [E_W+POS_W-1:0] num_x, num_y;

    // Table loading from the control path, clocked by the carrier's clock copy
    always_ff @(posedge i_clk)
    begin
        if (i_lut_we && i_lut_sel == 2'h0)
            xtal_map[i_lut_addr] <= i_lut_data[XTAL_W-1:0];
        if (i_lut_we && i_lut_sel == 2'h1)
            win_map[i_lut_addr] <= i_lut_data[0];
        if (i_lut_we && i_lut_sel == 2'h2)
            time_map[i_lut_addr] <= i_lut_data[TIME_W-1:0];
        if (i_lut_we && i_lut_sel == 2'h3)
            gain_map[i_lut_addr[7:0]] <= i_lut_data[7:0];
    end

    assign len = i_long_slice ? 5'(SLICE_LONG_CLKS) : 5'(SLICE_SHORT_CLKS);
    assign trig = |(i_disc & ~disc_q);
    // Numerators scaled by 64 so each quotient lands in six bits
    assign num_x = (E_W+POS_W)'(acc_q[0] + acc_q[1]) << POS_W;
    assign num_y = (E_W+POS_W)'(acc_q[0] + acc_q[2]) << POS_W;

    // Processing and slice framing next values
    always_comb
    begin
        st_d = st_q;
        icnt_d = icnt_q;
        raw_t_d = raw_t_q;
        e_d = e_q;
        x_d = x_q;
        y_d = y_q;
        xtal_d = xtal_q;
        pend_d = pend_q;
        pend_v_d = pend_v_q;
        lane_d = lane_q;
        // Count holds at the slice length if a boundary mark goes missing
        pos_d = i_slice ? 5'h1 : (pos_q >= len ? pos_q : pos_q + 5'h1);
        for (int c = 0; c < NCHAN; c++)
            acc_d[c] = acc_q[c];
        // Launch clears first, so a word finished in this same cycle
        // still stands pending for the next slice
        if (i_slice && pend_v_q)
        begin
            pend_v_d = 1'b0;
            lane_d = lane_q + 2'h1;
        end
        case (st_q)
            SEL_IDLE:
            begin
                if (trig)
                begin
                    st_d = SEL_INTEG;
                    icnt_d = 4'h0;
                    raw_t_d = TIME_W'({pos_q[3:0], 4'h0} | 8'(i_tdc_fine[TDC_W-1:0]));
                    for (int c = 0; c < NCHAN; c++)
                        acc_d[c] = '0;
                end
            end
            SEL_INTEG:
            begin
                // Fixed window of INT_LEN samples per channel
                for (int c = 0; c < NCHAN; c++)
                    acc_d[c] = acc_q[c] + INT_W'(i_adc[c*ADC_W +: ADC_W]);
                icnt_d = icnt_q + 4'h1;
                if (icnt_q == 4'(INT_LEN - 1))
                    st_d = SEL_CALC;
            end
            SEL_CALC:
            begin
                e_d = E_W'(acc_q[0]) + E_W'(acc_q[1]) + E_W'(acc_q[2]) + E_W'(acc_q[3]);
                st_d = SEL_LOOK;
            end
            default:
            begin
                // One-cycle divide is costly but stays within a slice
                if (e_q != '0)
                begin
                    x_d = POS_W'(num_x / (E_W+POS_W)'(e_q));
                    y_d = POS_W'(num_y / (E_W+POS_W)'(e_q));
                end
                xtal_d = xtal_map[{x_d, y_d}];
                if (win_map[{e_q[E_W-1:E_W-4], xtal_d}])
                begin
                    pend_v_d = 1'b1;
                    pend_d = '0;
                    pend_d[XTAL_W-1:0] = xtal_d;
                    pend_d[15:8] = time_map[{raw_t_q[3:0], xtal_d}];
                    pend_d[27:16] = 12'((26'(e_q) * 26'(gain_map[xtal_d])) >> 7);
                    pend_d[31:28] = PID_FIRST;
                    pend_d[PID_HI_LO +: PID_W] = PID_FIRST + 4'h1;
                end
                st_d = SEL_IDLE;
            end
        endcase
    end

    // Lane shifters, one per lane
    // Idle lanes load zero, which never carries a valid packet identifier
    always_comb
    begin
        for (int l = 0; l < NLANE; l++)
        begin
            sh_d[l] = sh_q[l] >> PAIRS;
            if (i_slice)
                sh_d[l] = (pend_v_q && lane_q == 2'(l)) ? pend_q : '0;
            if (!i_long_slice)
                sh_d[l][WORD_W-1:32] = '0;
        end
        lane_out_d = '0;
        for (int l = 0; l < NLANE; l++)
            lane_out_d[l*PAIRS +: PAIRS] = sh_d[l][PAIRS-1:0];
    end

    // State registers
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            st_q <= SEL_IDLE;
            pos_q <= 5'h0;
            disc_q <= '0;
            icnt_q <= 4'h0;
            raw_t_q <= '0;
            e_q <= '0;
            x_q <= '0;
            y_q <= '0;
            xtal_q <= '0;
            pend_q <= '0;
            pend_v_q <= 1'b0;
            lane_q <= 2'h0;
            o_lane <= '0;
            o_clk_fwd <= 1'b0;
            o_slice_fwd <= 1'b0;
            o_spare <= '0;
            for (int l = 0; l < NLANE; l++)
                sh_q[l] <= '0;
            for (int c = 0; c < NCHAN; c++)
                acc_q[c] <= '0;
        end
        else
        begin
            st_q <= st_d;
            pos_q <= pos_d;
            disc_q <= i_disc;
            icnt_q <= icnt_d;
            raw_t_q <= raw_t_d;
            e_q <= e_d;
            x_q <= x_d;
            y_q <= y_d;
            xtal_q <= xtal_d;
            pend_q <= pend_d;
            pend_v_q <= pend_v_d;
            lane_q <= lane_d;
            o_lane <= lane_out_d;
            o_clk_fwd <= ~o_clk_fwd;
            o_slice_fwd <= i_slice;
            o_spare <= i_spare;
            for (int l = 0; l < NLANE; l++)
                sh_q[l] <= sh_d[l];
            for (int c = 0; c < NCHAN; c++)
                acc_q[c] <= acc_d[c];
        end
    end

    // Forwarded timing, slice position and spare pairs
    a_slice_fwd: assert property (@(posedge i_clk) disable iff (i_srst)
        i_slice |=> o_slice_fwd)
        else $error("slice copy late");
    a_clk_toggle: assert property (@(posedge i_clk) disable iff (i_srst)
        o_clk_fwd |=> !o_clk_fwd)
        else $error("fwd clock stuck high");
    a_clk_rise: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_clk_fwd |=> o_clk_fwd)
        else $error("fwd clock stuck low");
    a_spare_copy: assert property (@(posedge i_clk) disable iff (i_srst)
        1'b1 |=> o_spare == $past(i_spare))
        else $error("spare copy");
    a_pos_restart: assert property (@(posedge i_clk) disable iff (i_srst)
        i_slice |=> pos_q == 5'h1)
        else $error("slice position");
    // Pipeline stages: eight-clock integration, then one-clock calculation and lookup
    a_trig_start: assert property (@(posedge i_clk) disable iff (i_srst)
        (st_q == SEL_IDLE && trig) |=> st_q == SEL_INTEG)
        else $error("no start");
    a_rise_only: assert property (@(posedge i_clk) disable iff (i_srst)
        (st_q == SEL_IDLE && !trig) |=> st_q == SEL_IDLE)
        else $error("start without edge");
    a_stamp_raw: assert property (@(posedge i_clk) disable iff (i_srst)
        (st_q == SEL_IDLE && trig) |=> raw_t_q[TDC_W-1:0] == $past(i_tdc_fine[TDC_W-1:0]))
        else $error("raw stamp");
    a_integ_len: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(st_q == SEL_INTEG) |-> ##8 st_q == SEL_CALC)
        else $error("window length");
    a_calc_one: assert property (@(posedge i_clk) disable iff (i_srst)
        st_q == SEL_CALC |=> st_q == SEL_LOOK)
        else $error("calc stage length");
    a_look_one: assert property (@(posedge i_clk) disable iff (i_srst)
        st_q == SEL_LOOK |=> st_q == SEL_IDLE)
        else $error("lookup stage length");
    a_window_gate: assert property (@(posedge i_clk) disable iff (i_srst)
        (st_q == SEL_LOOK && !pend_v_q && !win_map[{e_q[E_W-1:E_W-4], xtal_d}]) |=> !pend_v_q)
        else $error("rejected event kept");
    // Word contents and launch
    a_pid_valid: assert property (@(posedge i_clk) disable iff (i_srst)
        pend_v_q |-> pend_q[31:28] != 4'h0 && pend_q[31:28] <= PID_LAST)
        else $error("bad packet id");
    a_pid_second: assert property (@(posedge i_clk) disable iff (i_srst)
        pend_v_q |-> pend_q[63:60] == 4'h2)
        else $error("bad second packet id");
    a_launch_once: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_slice && pend_v_q) |=> !pend_v_q || $changed(pend_q))
        else $error("relaunch");
    a_launch_lane: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_slice && pend_v_q) |=> lane_q == $past(lane_q) + 2'h1)
        else $error("lane not advanced");
    a_idle_lanes: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_slice && !pend_v_q) |=> o_lane == '0)
        else $error("idle lane busy");
    a_short_word: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_long_slice |=> sh_q[0][WORD_W-1:32] == '0)
        else $error("wide word");
    a_lane_first: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_slice && pend_v_q && lane_q == 2'h0) |=> o_lane[3:0] == $past(pend_q[3:0]))
        else $error("lane nibble");
    // Main scenarios
    c_event: cover property (@(posedge i_clk) st_q == SEL_LOOK);
    c_send: cover property (@(posedge i_clk) i_slice && pend_v_q);
    c_long: cover property (@(posedge i_clk) i_long_slice && i_slice);
    c_reject: cover property (@(posedge i_clk)
        st_q == SEL_LOOK && !win_map[{e_q[E_W-1:E_W-4], xtal_d}]);
    c_lane_wrap: cover property (@(posedge i_clk) i_slice && pend_v_q && lane_q == 2'h3);
endmodule : sel_link

// ===== verif/sel_carrier_model.sv
/*
 Carrier card receiver model: rebuilds singles words from the lanes.
 Assumes lanes and forwarded slice are registered on i_clk.
*/
`timescale 1ns/10ps
module sel_carrier_model (
    input wire logic i_clk,
    input wire logic i_long,
    input wire logic i_slice_fwd,
    input wire logic [sel_pkg::NLANE*sel_pkg::PAIRS-1:0] i_lane,
    output logic [sel_pkg::NLANE-1:0] o_got,
    output logic [sel_pkg::WORD_W-1:0] o_word [sel_pkg::NLANE]
);
    import sel_pkg::*;
    logic [WORD_W-1:0] acc [NLANE];
    int k = 99;
    // Slice-aligned capture; idle lanes carry zero, never a valid id
    always @(posedge i_clk)
    begin
        k = i_slice_fwd ? 0 : k + 1;
        o_got <= '0;
        for (int l = 0; l < NLANE; l++)
        begin
            if (k == 0)
                acc[l] = '0;
            if (k < (i_long ? 16 : 8))
                acc[l][4*k +: 4] = i_lane[4*l +: 4];
            if (k == (i_long ? 15 : 7) && acc[l][31:28] != 4'h0)
            begin
                o_got[l] <= 1'b1;
                o_word[l] <= acc[l];
            end
        end
    end
endmodule : sel_carrier_model

// ===== verif/singles_event_link_test.sv
/*
 Self-checking bench: loads tables, sends accepted and rejected events.
 Assumes the carrier model in its own file and the sel_pkg constants.
*/
`timescale 1ns/10ps
module singles_event_link_test;
    import sel_pkg::*;
    typedef struct {int lane; logic lng; logic [7:0] t; logic [11:0] en;} sel_exp_s;
    logic i_clk = 0, i_srst = 1, i_slice = 0, i_long_slice = 0, i_lut_we = 0;
    logic [3:0] i_disc = 0;
    logic [47:0] i_adc = 0;
    logic [15:0] i_tdc_fine = 0, i_lut_data = 0, o_lane;
    logic [7:0] i_spare = 0, o_spare, xc, p_spare = 0;
    logic [1:0] i_lut_sel = 0;
    logic [11:0] i_lut_addr = 0;
    logic o_clk_fwd, o_slice_fwd, p_rst = 1, p_rst2 = 1, p_clkf = 0, p_slice = 0, p_on = 0;
    logic [3:0] got;
    logic [WORD_W-1:0] words [NLANE];
    sel_exp_s exp_q[$];
    int fail_count = 0, checked = 0, lane_n = 0, sc = 0, seed_v;
    sel_link dut (.i_clk(i_clk), .i_srst(i_srst), .i_slice(i_slice),
        .i_long_slice(i_long_slice), .i_disc(i_disc), .i_adc(i_adc),
        .i_tdc_fine(i_tdc_fine), .i_spare(i_spare), .i_lut_we(i_lut_we),
        .i_lut_sel(i_lut_sel), .i_lut_addr(i_lut_addr), .i_lut_data(i_lut_data),
        .o_clk_fwd(o_clk_fwd), .o_slice_fwd(o_slice_fwd), .o_lane(o_lane),
        .o_spare(o_spare));
    sel_carrier_model far (.i_clk(i_clk), .i_long(i_long_slice),
        .i_slice_fwd(o_slice_fwd), .i_lane(o_lane), .o_got(got), .o_word(words));
    always #4 i_clk = ~i_clk;
    task automatic stop_test();
        $display("Checks %0d, errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic chk(input bit ok, input string msg);
        checked++;
        if (!ok)
        begin
            fail_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk
    // Carrier slice marks and random spare traffic, just after each edge
    always @(posedge i_clk)
    begin
        #1;
        sc = (i_srst || sc == (i_long_slice ? 15 : 7)) ? 0 : sc + 1;
        i_slice = (sc == 1);
        i_spare = 8'($urandom);
    end
    // Forwarded timing, spare pairs and reset levels
    always @(posedge i_clk)
    begin
        // First edge skipped: outputs stay unknown until reset has landed
        if (p_rst && p_on)
            chk({o_lane, o_clk_fwd, o_slice_fwd, o_spare} === '0, "reset outputs");
        else if (!p_rst)
        begin
            chk(o_slice_fwd === p_slice, "slice copy");
            chk(o_spare === p_spare, "spare copy");
            if (!p_rst2)
                chk(o_clk_fwd === ~p_clkf, "clock copy");
        end
        p_rst <= i_srst;
        p_rst2 <= p_rst;
        p_clkf <= o_clk_fwd;
        p_slice <= i_slice;
        p_spare <= i_spare;
        p_on <= 1'b1;
    end
    // Oldest expectation against each word that the carrier rebuilds
    always @(posedge i_clk)
        for (int l = 0; l < NLANE; l++)
            if (got[l] === 1'b1)
            begin
                chk(exp_q.size() > 0, "unexpected word");
                if (exp_q.size() > 0)
                begin
                    automatic sel_exp_s e = exp_q.pop_front();
                    automatic logic [WORD_W-1:0] w = words[l];
                    chk(l == e.lane, "lane order");
                    chk(w[31:28] === PID_FIRST, "packet id");
                    chk(w[7:0] === xc, "crystal");
                    chk(w[27:16] === e.en, "energy");
                    chk(w[15:8] === e.t, "corrected time");
                    chk(w[63:60] === (e.lng ? 4'h2 : 4'h0), "word width");
                end
            end
    task automatic run_event(input bit pass);
        logic [3:0] f;
        int s;
        sel_exp_s e;
        @(posedge i_clk iff i_slice);
        #1;
        s = 0;
        // Window table passes only when energy bits 17:14 are nonzero
        for (int c = 0; c < NCHAN; c++)
        begin
            i_adc[c*12 +: 12] = pass ? 12'(512 + $urandom_range(3583)) : 12'($urandom_range(511));
            s += 8 * int'(i_adc[c*12 +: 12]);
        end
        f = 4'($urandom);
        i_tdc_fine = {12'($urandom), f};
        i_disc = 4'h1 << $urandom_range(3);
        // Gain table holds 0x80, so the energy field is the raw sum
        e = '{lane_n % NLANE, i_long_slice, {4'h5, f}, 12'(s)};
        if (pass)
        begin
            exp_q.push_back(e);
            lane_n++;
        end
        repeat (2) @(posedge i_clk);
        #1 i_disc = '0;
        repeat (40) @(posedge i_clk);
    endtask : run_event
    initial
    begin
        seed_v = $urandom(32'h6843);
        xc = 8'($urandom);
        repeat (3) @(posedge i_clk);
        #1 i_srst = 0;
        // Fill all four tables; crystal constant, time keyed by fine stamp
        for (int a = 0; a < 4 * 4096; a++)
        begin
            i_lut_we = 1;
            i_lut_sel = 2'(a >> 12);
            i_lut_addr = 12'(a);
            i_lut_data = i_lut_sel == 0 ? {8'h0, xc} : i_lut_sel == 1 ?
                16'(a[11:8] != 0) : i_lut_sel == 2 ? {8'h0, 4'h5, 4'(a >> 8)} : 16'h0080;
            @(posedge i_clk);
            #1;
        end
        i_lut_data = {8'h0, 4'h5, 4'h0} >> 4;
        i_lut_we = 0;
        for (int m = 0; m < 2; m++)
        begin
            if (m == 1)
            begin
                #1 i_srst = 1;
                i_long_slice = 1;
                lane_n = 0;
                repeat (3) @(posedge i_clk);
                #1 i_srst = 0;
            end
            for (int k = 0; k < 8; k++)
                run_event(k != 2 && k != 5);
        end
        repeat (20) @(posedge i_clk);
        chk(exp_q.size() == 0, "missing words");
        stop_test();
    end
    initial
    begin
        #400000;
        chk(0, "timeout");
        stop_test();
    end
endmodule : singles_event_link_test
